// ==== rtl/tsq_pkg.sv ====
// tsq_pkg: shared constants and types of the trace sequencer
package tsq_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DEPTH = 64;
  localparam int NLVL = 8;
  localparam int NCOND = 32;
  localparam int COND_W = 10;
  localparam logic [6:0] FILL_MAX = 7'h40;
  localparam logic [6:0] HALF_FILL = 7'h20;
  // ----------------------------------------------------------------
  // register offsets (8-bit address, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_COUNT = 8'h02;
  localparam logic [7:0] REG_BIDX = 8'h04;
  localparam logic [7:0] REG_BADDR = 8'h05;
  localparam logic [7:0] REG_BDATA = 8'h06;
  localparam logic [7:0] REG_BSTAT = 8'h07;
  localparam logic [7:0] REG_DEST = 8'h10;
  localparam logic [7:0] DEST_MASK = 8'hf8;
  localparam logic [7:0] REG_COND = 8'h20;
  localparam logic [7:0] COND_MASK = 8'he0;
  // ----------------------------------------------------------------
  // control fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_START = 0;
  localparam int CTL_MULTI = 1;
  localparam int CTL_PLACE = 2;
  localparam int CTL_BRK = 4;
  localparam int CTL_CNT = 5;
  localparam int CTL_TLVL = 8;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [9:0] COND_RST = 10'h000;
  localparam logic [7:0] DEST_RST = 8'h00;
  localparam int DEST_SEC = 4;
  localparam int CF_ANY = 8;
  localparam int CF_NEG = 9;
  localparam logic [1:0] PLACE_START = 2'h0;
  localparam logic [1:0] PLACE_CENTER = 2'h1;
  localparam logic [1:0] CNT_TIME = 2'h1;
  localparam logic [1:0] CNT_STATE = 2'h2;
  // ----------------------------------------------------------------
  // condition slots: two-term set, then per-level sets
  // ----------------------------------------------------------------
  localparam int CI_ENSTORE = 0;
  localparam int CI_ENABLE = 1;
  localparam int CI_TRSTORE = 2;
  localparam int CI_TRIGGER = 3;
  localparam int CI_STORE = 4;
  localparam int CI_RESTART = 5;
  localparam int CI_COUNTQ = 6;
  localparam int CI_PRESTORE = 7;
  localparam int CI_PRI = 8;
  localparam int CI_SEC = 16;
  localparam int CI_LSTORE = 24;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SQ_IDLE, SQ_RUN, SQ_DONE} tsq_seq_e;
  typedef logic [5:0] tsq_ptr_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0] stat;
  } tsq_state_s;
  typedef struct packed {
    tsq_state_s st;
    logic pre;
    logic trig;
  } tsq_entry_s;
endpackage

// ==== rtl/tsq_cond.sv ====
// tsq_cond: one qualifier, an OR of selected pattern matches
`timescale 1ns/1ns
module tsq_cond (
  // condition word and pattern hits
  input wire logic [9:0] cond_in,
  input wire logic [7:0] match_in,
  // result
  output logic hit_out
);
  // any-state bit forces a hit; the negate bit gives the NOT form
  wire logic raw = cond_in[tsq_pkg::CF_ANY] | (|(cond_in[7:0] & match_in));
  assign hit_out = raw ^ cond_in[tsq_pkg::CF_NEG];
endmodule // tsq_cond

// ==== rtl/tsq_tbuf.sv ====
// tsq_tbuf: trace buffer storage, up to three writes per cycle
`timescale 1ns/1ns
module tsq_tbuf (
  // clock
  input wire logic clk_in,
  input wire logic en_in,
  // write side, entries oldest first
  input wire logic [1:0] wr_n_in,
  input wire tsq_pkg::tsq_ptr_t wr_ptr_in,
  input wire tsq_pkg::tsq_entry_s [2:0] wr_ent_in,
  // read side
  input wire tsq_pkg::tsq_ptr_t rd_ptr_in,
  output tsq_pkg::tsq_entry_s rd_ent_out
);
  tsq_pkg::tsq_entry_s mem [tsq_pkg::DEPTH];

  // pointer arithmetic wraps at the depth, so the store is circular
  always_ff @(posedge clk_in) begin
    if (en_in) begin
      for (int k = 0; k < 3; k++) begin
        if (2'(k) < wr_n_in) begin
          mem[wr_ptr_in + 6'(k)] <= wr_ent_in[k];
        end
      end
    end
  end

  assign rd_ent_out = mem[rd_ptr_in];
endmodule // tsq_tbuf

// ==== rtl/tsq_top.sv ====
// tsq_top: trace sequencer, trigger placement and storage qualification
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
module tsq_top (
  // clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // captured bus states and pattern comparator hits
  input wire logic STATE_VALID_IN,
  input wire tsq_pkg::tsq_state_s STATE_IN,
  input wire logic [7:0] PATTERN_MATCH_IN,
  // status and break request
  output logic RUNNING_OUT,
  output logic TRIGGERED_OUT,
  output logic COMPLETE_OUT,
  output logic [2:0] LEVEL_OUT,
  output logic BREAK_OUT
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [9:0] cond [tsq_pkg::NCOND];
  logic [7:0] dest [tsq_pkg::NLVL];
  tsq_pkg::tsq_seq_e seq;
  logic [2:0] lvl;
  logic trig;
  tsq_pkg::tsq_ptr_t wptr;
  tsq_pkg::tsq_ptr_t bidx;
  logic [6:0] fill;
  logic [6:0] post;
  logic [1:0] pre_n;
  tsq_pkg::tsq_state_s pre0;
  tsq_pkg::tsq_state_s pre1;
  logic [31:0] count;
  logic brk;
  logic [31:0] rd_data;
  logic [2:0] next_lvl;
  logic [tsq_pkg::NCOND-1:0] hit;
  tsq_pkg::tsq_entry_s rd_ent;

  // ----------------------------------------------------------------
  // register decode and control fields
  // ----------------------------------------------------------------
  wire logic wr_ctrl = REG_WR_IN & (REG_ADDR_IN == tsq_pkg::REG_CTRL);
  wire logic start = wr_ctrl & REG_WDATA_IN[tsq_pkg::CTL_START];
  wire logic sel_cond = (REG_ADDR_IN & tsq_pkg::COND_MASK) == tsq_pkg::REG_COND;
  wire logic sel_dest = (REG_ADDR_IN & tsq_pkg::DEST_MASK) == tsq_pkg::REG_DEST;
  wire logic multi = ctrl[tsq_pkg::CTL_MULTI];
  wire logic [1:0] place = ctrl[tsq_pkg::CTL_PLACE +: 2];
  wire logic brk_en = ctrl[tsq_pkg::CTL_BRK];
  wire logic [1:0] cnt_mode = ctrl[tsq_pkg::CTL_CNT +: 2];
  wire logic [2:0] tlvl = ctrl[tsq_pkg::CTL_TLVL +: 3];
  wire logic is_start = place == tsq_pkg::PLACE_START;
  wire logic is_center = place == tsq_pkg::PLACE_CENTER;
  wire logic is_end = !is_start & !is_center;

  // ----------------------------------------------------------------
  // qualifiers: one evaluator per condition slot
  // ----------------------------------------------------------------
  for (genvar g = 0; g < tsq_pkg::NCOND; g++) begin : g_cond
    tsq_cond u_cond (
      .cond_in(cond[g]),
      .match_in(PATTERN_MATCH_IN),
      .hit_out(hit[g])
    );
  end

  // a state counts only while running; no status filter is applied, so
  // prefetched but unexecuted cycles are traced like any other
  wire logic act = STATE_VALID_IN & (seq == tsq_pkg::SQ_RUN);

  // ----------------------------------------------------------------
  // multilevel branch selection
  // ----------------------------------------------------------------
  // each of the eight levels owns a primary, a secondary and a store slot
  wire logic [7:0] pri_v = hit[tsq_pkg::CI_PRI +: tsq_pkg::NLVL];
  wire logic [7:0] sec_v = hit[tsq_pkg::CI_SEC +: tsq_pkg::NLVL];
  wire logic [7:0] lst_v = hit[tsq_pkg::CI_LSTORE +: tsq_pkg::NLVL];
  wire logic pri = pri_v[lvl];
  wire logic sec = sec_v[lvl];
  wire logic [2:0] dest_pri = dest[lvl][2:0];
  wire logic [2:0] dest_sec = dest[lvl][tsq_pkg::DEST_SEC +: 3];
  wire logic ml_branch = pri | sec;
  wire logic [2:0] ml_dest = pri ? dest_pri : dest_sec;

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  // entering the chosen level fires, even by a branch onto itself
  wire logic ml_fire = ml_branch & (ml_dest == tlvl);
  wire logic tt_fire = (lvl == 3'h1) & hit[tsq_pkg::CI_TRIGGER];
  wire logic fire = act & !trig & (multi ? ml_fire : tt_fire);

  // ----------------------------------------------------------------
  // store qualification by phase and placement
  // ----------------------------------------------------------------
  wire logic tt_pre = (lvl == 3'h0) ? hit[tsq_pkg::CI_ENSTORE]
                                    : hit[tsq_pkg::CI_TRSTORE];
  wire logic q_pre = multi ? lst_v[lvl] : tt_pre;
  wire logic q_post = multi ? lst_v[lvl] : hit[tsq_pkg::CI_STORE];
  // start drops pre-trigger states, end drops post-trigger states,
  // center keeps both; the triggering state itself is always kept
  wire logic keep_pre = q_pre & !is_start;
  wire logic keep_post = q_post & !is_end;
  wire logic keep = fire | (trig ? keep_post : keep_pre);
  wire logic norm = act & keep;
  wire logic pq = act & !norm & hit[tsq_pkg::CI_PRESTORE];

  // ----------------------------------------------------------------
  // write shaping: prestored states first, then the normal state
  // ----------------------------------------------------------------
  wire tsq_pkg::tsq_entry_s cur_e = '{st: STATE_IN, pre: 1'b0, trig: fire};
  wire tsq_pkg::tsq_entry_s p0_e = '{st: pre0, pre: 1'b1, trig: 1'b0};
  wire tsq_pkg::tsq_entry_s p1_e = '{st: pre1, pre: 1'b1, trig: 1'b0};
  wire tsq_pkg::tsq_entry_s [2:0] ents = {
    cur_e,
    (pre_n == 2'h2) ? p1_e : cur_e,
    (pre_n == 2'h0) ? cur_e : p0_e
  };
  wire logic [1:0] n_raw = norm ? pre_n + 2'h1 : 2'h0;
  // room left: start fills once, center fills half after the trigger;
  // when room is short the newest entries of the group are lost
  wire logic [6:0] lim = is_start ? tsq_pkg::FILL_MAX - fill
                       : (trig & is_center) ? tsq_pkg::HALF_FILL - post
                       : 7'h3;
  wire logic [1:0] wr_n = ({5'h0, n_raw} > lim) ? lim[1:0] : n_raw;
  wire logic [6:0] fill_sum = fill + {5'h0, wr_n};
  wire logic [6:0] next_fill = (fill_sum > tsq_pkg::FILL_MAX) ? tsq_pkg::FILL_MAX
                                                             : fill_sum;
  wire logic [6:0] post_sum = post + (trig ? {5'h0, wr_n} : 7'h0);

  // ----------------------------------------------------------------
  // completion
  // ----------------------------------------------------------------
  wire logic done_start = is_start & (fill_sum >= tsq_pkg::FILL_MAX);
  wire logic done_center = is_center & trig & (post_sum >= tsq_pkg::HALF_FILL);
  wire logic done_end = is_end & fire;
  wire logic done_now = act & (done_start | done_center | done_end);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wire logic cnt_state = (cnt_mode == tsq_pkg::CNT_STATE) & act & hit[tsq_pkg::CI_COUNTQ];
  wire logic cnt_inc = (seq == tsq_pkg::SQ_RUN)
                     & ((cnt_mode == tsq_pkg::CNT_TIME) | cnt_state);

  // ----------------------------------------------------------------
  // level sequencing
  // ----------------------------------------------------------------
  // two-term: restart beats enable; a trigger hit at level 1 freezes the level
  always_comb begin
    next_lvl = lvl;
    if (multi) begin
      if (act & ml_branch) begin
        next_lvl = ml_dest;
      end
    end else if (act & !trig & !fire) begin
      if (hit[tsq_pkg::CI_RESTART]) begin
        next_lvl = 3'h0;
      end else if ((lvl == 3'h0) & hit[tsq_pkg::CI_ENABLE]) begin
        next_lvl = 3'h1;
      end
    end
  end

  // sequencer state; a start command rearms everything
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      seq <= tsq_pkg::SQ_IDLE;
      lvl <= 3'h0;
      trig <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (start) begin
        seq <= tsq_pkg::SQ_RUN;
        lvl <= 3'h0;
        trig <= 1'b0;
      end else if (seq == tsq_pkg::SQ_RUN) begin
        lvl <= next_lvl;
        trig <= trig | fire;
        if (done_now) begin
          seq <= tsq_pkg::SQ_DONE;
        end
      end
    end
  end

  // buffer pointers; nothing moves once done, so the trace is frozen
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wptr <= 6'h0;
      fill <= 7'h0;
      post <= 7'h0;
    end else if (CLK_EN_IN) begin
      if (start) begin
        wptr <= 6'h0;
        fill <= 7'h0;
        post <= 7'h0;
      end else if (seq == tsq_pkg::SQ_RUN) begin
        wptr <= wptr + {4'h0, wr_n};
        fill <= next_fill;
        post <= post_sum;
      end
    end
  end

  // prestore holding pair: the newest two candidates survive
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pre_n <= 2'h0;
    end else if (CLK_EN_IN) begin
      if (start | norm) begin
        pre_n <= 2'h0;
      end else if (pq & (pre_n != 2'h2)) begin
        pre_n <= pre_n + 2'h1;
      end
    end
  end

  // prestore data carries no control meaning, so it has no reset
  always_ff @(posedge CLOCK_IN) begin
    if (CLK_EN_IN & pq & !start) begin
      if (pre_n == 2'h0) begin
        pre0 <= STATE_IN;
      end else if (pre_n == 2'h1) begin
        pre1 <= STATE_IN;
      end else begin
        pre0 <= pre1;
        pre1 <= STATE_IN;
      end
    end
  end

  // counter and one-cycle break request
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      count <= 32'h0;
      brk <= 1'b0;
    end else if (CLK_EN_IN) begin
      count <= start ? 32'h0 : count + {31'h0, cnt_inc};
      brk <= fire & brk_en & !start;
    end
  end

  // ----------------------------------------------------------------
  // trace storage
  // ----------------------------------------------------------------
  // readout index 0 is always the oldest entry held
  wire tsq_pkg::tsq_ptr_t rd_ptr = wptr - fill[5:0] + bidx;
  wire logic [1:0] buf_n = (CLK_EN_IN & !start) ? wr_n : 2'h0;

  tsq_tbuf u_tbuf (
    .clk_in(CLOCK_IN),
    .en_in(CLK_EN_IN),
    .wr_n_in(buf_n),
    .wr_ptr_in(wptr),
    .wr_ent_in(ents),
    .rd_ptr_in(rd_ptr),
    .rd_ent_out(rd_ent)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // the start bit is a command and never reads back as set
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl <= tsq_pkg::CTRL_RST;
      bidx <= 6'h0;
      for (int i = 0; i < tsq_pkg::NCOND; i++) begin
        cond[i] <= tsq_pkg::COND_RST;
      end
      for (int i = 0; i < tsq_pkg::NLVL; i++) begin
        dest[i] <= tsq_pkg::DEST_RST;
      end
    end else if (CLK_EN_IN & REG_WR_IN) begin
      if (wr_ctrl) begin
        ctrl <= REG_WDATA_IN & ~(32'h1 << tsq_pkg::CTL_START);
      end
      if (REG_ADDR_IN == tsq_pkg::REG_BIDX) begin
        bidx <= REG_WDATA_IN[5:0];
      end
      if (sel_cond) begin
        cond[REG_ADDR_IN[4:0]] <= REG_WDATA_IN[9:0];
      end
      if (sel_dest) begin
        dest[REG_ADDR_IN[2:0]] <= REG_WDATA_IN[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // status: fill[14:8], level[6:4], done[2], triggered[1], running[0]
  wire logic [31:0] status_w = {17'h0, fill, 1'b0, lvl, 1'b0, COMPLETE_OUT,
                                trig, RUNNING_OUT};
  wire logic [31:0] bstat_w = {22'h0, rd_ent.trig, rd_ent.pre, rd_ent.st.stat};
  wire logic [31:0] rd_mux =
    (REG_ADDR_IN == tsq_pkg::REG_CTRL) ? ctrl :
    (REG_ADDR_IN == tsq_pkg::REG_STATUS) ? status_w :
    (REG_ADDR_IN == tsq_pkg::REG_COUNT) ? count :
    (REG_ADDR_IN == tsq_pkg::REG_BIDX) ? {26'h0, bidx} :
    (REG_ADDR_IN == tsq_pkg::REG_BADDR) ? rd_ent.st.addr :
    (REG_ADDR_IN == tsq_pkg::REG_BDATA) ? rd_ent.st.data :
    (REG_ADDR_IN == tsq_pkg::REG_BSTAT) ? bstat_w :
    sel_cond ? {22'h0, cond[REG_ADDR_IN[4:0]]} :
    sel_dest ? {24'h0, dest[REG_ADDR_IN[2:0]]} :
    32'h0;

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rd_data <= 32'h0;
    end else if (CLK_EN_IN) begin
      rd_data <= REG_RD_IN ? rd_mux : 32'h0;
    end
  end

  assign REG_RDATA_OUT = rd_data;
  assign RUNNING_OUT = seq == tsq_pkg::SQ_RUN;
  assign COMPLETE_OUT = seq == tsq_pkg::SQ_DONE;
  assign TRIGGERED_OUT = trig;
  assign LEVEL_OUT = lvl;
  assign BREAK_OUT = brk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);

  wire logic step = CLK_EN_IN & !start;

  sequence s_fire_brk;
    step && fire && brk_en;
  endsequence
  sequence s_fire_end;
    step && fire && is_end;
  endsequence

  a_break_on_trig: assert property (s_fire_brk |=> BREAK_OUT ##1 !BREAK_OUT)
    else $error("break request missing or too long");
  a_restart_level: assert property (step && !multi && act && !trig && !fire
    && hit[tsq_pkg::CI_RESTART] |=> lvl == 3'h0)
    else $error("restart did not return to first level");
  a_enable_adv: assert property (step && !multi && act && lvl == 3'h0
    && !hit[tsq_pkg::CI_RESTART] && hit[tsq_pkg::CI_ENABLE] |=> lvl == 3'h1)
    else $error("first term did not advance level");
  a_primary_wins: assert property (step && multi && act && pri && sec
    |=> lvl == $past(dest_pri))
    else $error("secondary branch taken over primary");
  a_level_hold: assert property (step && multi && act && !pri && !sec
    |=> $stable(lvl))
    else $error("level moved without a branch");
  a_trig_entry: assert property (step && multi && act && !trig && ml_branch
    && ml_dest == tlvl |=> TRIGGERED_OUT && lvl == tlvl)
    else $error("entry to trigger level did not trigger");
  a_start_no_pre: assert property (step && is_start && act && !trig && !fire
    |=> $stable(wptr))
    else $error("pre-trigger state stored at start placement");
  a_end_last: assert property (s_fire_end |=> COMPLETE_OUT ##1 $stable(wptr))
    else $error("trace kept running after trigger at end");
  a_center_half: assert property (step && is_center && act && trig
    && post_sum >= tsq_pkg::HALF_FILL |=> COMPLETE_OUT)
    else $error("center trace did not stop at half");
  a_done_frozen: assert property (COMPLETE_OUT && !start |=> COMPLETE_OUT
    && $stable(wptr) && $stable(fill))
    else $error("storing continued after completion");
  a_count_time: assert property (step && RUNNING_OUT
    && cnt_mode == tsq_pkg::CNT_TIME |=> count == $past(count) + 32'h1)
    else $error("time count did not advance");
endmodule // tsq_top

// ==== bench/tsq_bus_model.sv ====
// tsq_bus_model: probed processor bus presenting captured states
`timescale 1ns/1ns
module tsq_bus_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bench request
  input wire logic req_in,
  input wire logic [7:0] mat_in,
  // states toward the sequencer
  output logic valid_out,
  output tsq_pkg::tsq_state_s state_out,
  output logic [7:0] match_out
);
  // one state per cycle while asked, prefetches included; idle lines keep toggling
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      state_out <= '0;
      match_out <= 8'h00;
    end else begin
      valid_out <= req_in;
      if (req_in) begin
        state_out.addr <= state_out.addr + 32'h4;
        match_out <= mat_in;
      end else begin
        state_out <= ~state_out; // stale values must not look valid
        match_out <= ~match_out;
      end
    end
  end
endmodule // tsq_bus_model

// ==== bench/tb_tsq_top.sv ====
// tb_tsq_top: self-checking bench of the trace sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_tsq_top;
  logic CLOCK_IN = 1'b0, RESET_IN = 1'b1, en = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0;
  logic [7:0] addr = 8'h00, mat = 8'h00, pmatch;
  logic [31:0] wd = 32'h0, rdata, v, v0;
  logic valid, running, trig, done, brk;
  logic [2:0] level;
  tsq_pkg::tsq_state_s st_bus;
  int n_errors = 0, n_compared = 0, n_brk = 0;
  always #5 CLOCK_IN = ~CLOCK_IN;
  always @(posedge CLOCK_IN) if (brk === 1'b1) n_brk++;
  tsq_bus_model tsq_bus_model_inst (.clk_in(CLOCK_IN), .rst_in(RESET_IN), .req_in(req),
    .mat_in(mat), .valid_out(valid), .state_out(st_bus), .match_out(pmatch));
  tsq_top tsq_top_inst (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .CLK_EN_IN(en),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .STATE_VALID_IN(valid), .STATE_IN(st_bus),
    .PATTERN_MATCH_IN(pmatch), .RUNNING_OUT(running), .TRIGGERED_OUT(trig),
    .COMPLETE_OUT(done), .LEVEL_OUT(level), .BREAK_OUT(brk));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic rst();
    @(posedge CLOCK_IN) RESET_IN <= 1'b1;
    repeat (2) @(posedge CLOCK_IN);
    RESET_IN <= 1'b0;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_IN) begin addr <= a; wd <= d; wr <= 1'b1; end
    @(posedge CLOCK_IN) wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge CLOCK_IN) begin addr <= a; rd <= 1'b1; end
    @(posedge CLOCK_IN) rd <= 1'b0;
    #1 v = rdata;
  endtask
  // n back-to-back states with one match pattern, then let outputs settle
  task automatic st(input logic [7:0] m, input int n);
    @(posedge CLOCK_IN) begin req <= 1'b1; mat <= m; end
    repeat (n) @(posedge CLOCK_IN);
    req <= 1'b0;
    repeat (3) @(posedge CLOCK_IN);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // two-term condition set shared by the placement tests
  task automatic two_term(input logic [9:0] en_c, input logic [9:0] tr_c);
    rst();
    wrr(8'h20, 32'h100);
    wrr(8'h21, {22'h0, en_c});
    wrr(8'h22, 32'h100);
    wrr(8'h23, {22'h0, tr_c});
    wrr(8'h24, 32'h100);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  initial begin
    rst();
    rdr(8'h00); `CHK(v, 32'h0)
    rdr(8'h08); `CHK(v, 32'h0)
    wrr(8'h08, 32'hffffffff);
    rdr(8'h08); `CHK(v, 32'h0)
    `CHK(running, 1'b0)
    // start placement, break on, state counting, restart
    two_term(10'h001, 10'h002);
    wrr(8'h25, 32'h004);
    wrr(8'h26, 32'h001);
    wrr(8'h00, 32'h51);
    st(8'h00, 1); `CHK(level, 3'h0)
    `CHK(running, 1'b1)
    st(8'h01, 1); `CHK(level, 3'h1)
    st(8'h04, 1); `CHK(level, 3'h0)
    st(8'h01, 1); `CHK(level, 3'h1)
    st(8'h02, 1); `CHK(trig, 1'b1)
    `CHK(n_brk, 1)
    rdr(8'h01); `CHK(v[14:8], 7'h01)
    wrr(8'h04, 32'h0);
    rdr(8'h07); `CHK(v[9], 1'b1)
    st(8'h00, 63); `CHK(done, 1'b1)
    `CHK(running, 1'b0)
    st(8'h00, 4);
    rdr(8'h01); `CHK(v[14:8], 7'h40)
    rdr(8'h02); `CHK(v, 32'h2)
    // center placement: half buffer after the trigger, no break
    two_term(10'h100, 10'h002);
    wrr(8'h00, 32'h05);
    st(8'h00, 40);
    rdr(8'h01); `CHK(v[14:8], 7'h28)
    st(8'h02, 1);
    st(8'h00, 30); `CHK(done, 1'b0)
    st(8'h00, 10); `CHK(done, 1'b1)
    rdr(8'h01); `CHK(v[14:8], 7'h40)
    rdr(8'h02); `CHK(v, 32'h0)
    `CHK(n_brk, 1)
    // end placement, time counting
    two_term(10'h100, 10'h002);
    wrr(8'h00, 32'h29);
    st(8'h00, 5);
    st(8'h02, 1);
    st(8'h00, 3);
    rdr(8'h01); `CHK(v[14:8], 7'h06)
    rdr(8'h02); `CHK(v != 32'h0, 1'b1)
    // prestore: four unstored states before the trigger, only the newest two survive
    two_term(10'h100, 10'h002);
    wrr(8'h22, 32'h004);
    wrr(8'h27, 32'h100);
    wrr(8'h00, 32'h09);
    st(8'h00, 5);
    st(8'h02, 1); `CHK(done, 1'b1)
    rdr(8'h01); `CHK(v[14:8], 7'h04)
    wrr(8'h04, 32'h1);
    rdr(8'h07); `CHK(v[9:8], 2'h1)
    rdr(8'h05);
    v0 = v;
    wrr(8'h04, 32'h2);
    rdr(8'h05); `CHK(v - v0, 32'h4)
    wrr(8'h04, 32'h3);
    rdr(8'h07); `CHK(v[9:8], 2'h2)
    // multilevel walk through all eight levels, trigger on the last
    rst();
    wrr(8'h28, 32'h001);
    wrr(8'h30, 32'h002);
    wrr(8'h38, 32'h100);
    wrr(8'h10, 32'h51);
    for (int l = 1; l < 8; l++) begin
      wrr(8'h28 + 8'(l), 32'h100);
      wrr(8'h10 + 8'(l), 32'((l + 1) % 8));
    end
    wrr(8'h00, 32'h707);
    st(8'h00, 1); `CHK(level, 3'h0)
    st(8'h03, 1); `CHK(level, 3'h1)
    for (int l = 2; l < 8; l++) begin
      st(8'h00, 1); `CHK(level, 3'(l))
      `CHK(trig, 1'(l == 7))
    end
    // a state offered while the enable is low must not move the level
    @(posedge CLOCK_IN) en <= 1'b0;
    st(8'h00, 1);
    @(posedge CLOCK_IN) en <= 1'b1;
    `CHK(level, 3'h7)
    rdr(8'h01); `CHK(v[14:8], 7'h03)
    wrap_up();
  end
endmodule // tb_tsq_top
